// file: rtl/mmu_defs.vh
`ifndef MMU_DEFS_VH
`define MMU_DEFS_VH

// ************************************************************
// address layout
// ************************************************************
`define VA_W        30
`define PA_W        26
`define PPTR_W      14
`define OFS_W       12
`define PERM_W      2
`define GRP_MSB     29
`define GRP_LSB     26
`define SEG_MSB     25
`define SEG_LSB     16
`define PGI_MSB     15
`define PGI_LSB     12
`define HALF_BIT    2

// ************************************************************
// page translation cache: 2K entries of 14-bit pointers (8KB)
// ************************************************************
`define TC_N        2048
`define TC_IDX_W    11
`define TC_IDX_LSB  12
`define TC_TAG_W    7
`define TC_TAG_LSB  23

// ************************************************************
// memory cache: 16K lines of 8 bytes (128KB)
// ************************************************************
`define MC_N        16384
`define MC_IDX_W    14
`define MC_IDX_LSB  3
`define MC_TAG_W    9
`define MC_TAG_LSB  17
`define LINE_W      64

// ************************************************************
// on-board tables
// ************************************************************
`define GT_N        16
`define MAP_N       4096
`define MAP_IDX_W   12
`define TBL_W       16

// ************************************************************
// table entry field positions (longword segment and page entries, 16-bit map entries)
// ************************************************************
`define STE_PTR_W   20
`define STE_PTR_LSB 0
`define STE_PRM_LSB 20
`define PTE_PTR_LSB 0
`define PTE_PRM_LSB 14
`define MAP_PTR_LSB 0
`define MAP_PRM_LSB 14

`endif

// file: rtl/tag_match.v
`timescale 1ns/1ps

// ************************************************************
// tag compare for one cache way
// ************************************************************
module tag_match #(
	parameter TAG_W = 8
) (
	input  wire [TAG_W-1:0] stored_tag_i,
	input  wire [TAG_W-1:0] addr_tag_i,
	input  wire             valid_i,
	output wire             hit_o,
	output wire             miss_o
);

	// a clear valid bit forces a miss whatever the tag holds
	assign hit_o  = valid_i & (stored_tag_i == addr_tag_i); // R02
	assign miss_o = ~valid_i | (stored_tag_i != addr_tag_i); // R03

endmodule

// file: rtl/mmu_cache_lookup.v
`timescale 1ns/1ps
`include "mmu_defs.vh"

// Summary of operation
// (R01) low address bits index both caches; upper bits compared with stored tag
// (R02) hit only when tag equal and tag valid bit set
// (R03) miss when tag unequal or tag valid bit clear
// (R04) memory cache holds 128KB: line, dirty bit, tag, valid per entry
// (R05) dma misses never allocate or update a cache entry
// (R06) any write to a memory cache location sets its dirty bit
// (R07) physical address is 14-bit page pointer above 12-bit byte offset
// (R08) pointer from translation cache hit, table walk on miss, mapper for dma
// (R09) first level is on-board 16-entry table of 14-bit segment table pointers
// (R10) third level in memory gives 14-bit page pointer plus permission bits
// (R11) dma mapper maps 16MB dma space onto 64MB; pointer plus permissions
// (R12) pages are 4096 bytes; offset passes through unchanged
// (R13) every main memory access moves one whole eight-byte line
// (R14) translation cache is 8KB, 2K entries: pointer, permissions, tag, valid
// (R15) segment fetch address is pointer, 10-bit index, two zero bits
// (R16) write miss first copies a dirty resident line back to memory
// (R17) reset clears every tag valid bit of both caches
module mmu_cache_lookup (
	input  wire                 clk_i,
	input  wire                 reset_n_i,
	input  wire                 req_i,
	input  wire                 req_dma_i,
	input  wire                 req_we_i,
	input  wire [`VA_W-1:0]     req_addr_i,
	input  wire [3:0]           req_be_i,
	input  wire [31:0]          req_wdata_i,
	output wire                 busy_o,
	output wire                 done_o,
	output wire [31:0]          rdata_o,
	output wire [`PA_W-1:0]     paddr_o,
	output wire [`PERM_W-1:0]   perm_o,
	output wire                 tc_hit_o,
	output wire                 mc_hit_o,
	input  wire                 tbl_we_i,
	input  wire                 tbl_map_i,
	input  wire [`MAP_IDX_W-1:0] tbl_idx_i,
	input  wire [`TBL_W-1:0]    tbl_data_i,
	output wire                 mem_req_o,
	output wire                 mem_we_o,
	output wire [`PA_W-1:0]     mem_addr_o,
	output wire [`LINE_W-1:0]   mem_wdata_o,
	input  wire                 mem_ack_i,
	input  wire [`LINE_W-1:0]   mem_rdata_i
);

	// ************************************************************
	// states
	// ************************************************************
	localparam [3:0] S_IDLE   = 4'h0;
	localparam [3:0] S_XLATE  = 4'h1;
	localparam [3:0] S_SEG_RD = 4'h2;
	localparam [3:0] S_PG_RD  = 4'h3;
	localparam [3:0] S_CACHE  = 4'h4;
	localparam [3:0] S_WB     = 4'h5;
	localparam [3:0] S_FILL   = 4'h6;
	localparam [3:0] S_DMA_RD = 4'h7;
	localparam [3:0] S_DMA_WR = 4'h8;

	// ************************************************************
	// storage
	// ************************************************************
	reg [`PPTR_W-1:0]    tc_ptr   [0:`TC_N-1];
	reg [`PERM_W-1:0]    tc_perm  [0:`TC_N-1];
	reg [`TC_TAG_W-1:0]  tc_tag   [0:`TC_N-1];
	reg [`TC_N-1:0]      tc_vld_q;
	reg [`LINE_W-1:0]    mc_data  [0:`MC_N-1];
	reg [`MC_TAG_W-1:0]  mc_tag   [0:`MC_N-1];
	reg [`MC_N-1:0]      mc_vld_q;
	reg [`MC_N-1:0]      mc_dirty_q;
	reg [`PPTR_W-1:0]    grp_tab  [0:`GT_N-1];
	reg [`TBL_W-1:0]     map_tab  [0:`MAP_N-1];

	reg [3:0]            state_q;
	reg                  dma_q;
	reg                  we_q;
	reg [`VA_W-1:0]      va_q;
	reg [3:0]            be_q;
	reg [31:0]           wd_q;
	reg [`PPTR_W-1:0]    ptr_q;
	reg [`PERM_W-1:0]    perm_q;
	reg                  done_q;
	reg [31:0]           rdata_q;
	reg                  tc_hit_q;
	reg                  mc_hit_q;
	reg [`PA_W-1:0]      mem_addr_q;
	reg [`LINE_W-1:0]    mem_wdata_q;

	// ************************************************************
	// address fields and lookups
	// ************************************************************
	wire [`TC_IDX_W-1:0]  tc_idx  = va_q[`TC_IDX_LSB+`TC_IDX_W-1:`TC_IDX_LSB]; // R01
	wire [`TC_TAG_W-1:0]  va_tag  = va_q[`VA_W-1:`TC_TAG_LSB];
	wire [`PA_W-1:0]      pa      = {ptr_q, va_q[`OFS_W-1:0]}; // R07 R12
	wire [`MC_IDX_W-1:0]  mc_idx  = pa[`MC_TAG_LSB-1:`MC_IDX_LSB]; // R01
	wire [`MC_TAG_W-1:0]  pa_tag  = pa[`PA_W-1:`MC_TAG_LSB];
	wire [`LINE_W-1:0]    mc_line = mc_data[mc_idx];
	wire [`MC_TAG_W-1:0]  mc_old_tag = mc_tag[mc_idx];
	wire [`TBL_W-1:0]     map_ent = map_tab[va_q[`OFS_W+`MAP_IDX_W-1:`OFS_W]]; // R11
	wire                  tc_hit;
	wire                  mc_hit;

	tag_match #(
		.TAG_W        (`TC_TAG_W)
	) u_tc_match (
		.stored_tag_i (tc_tag[tc_idx]),
		.addr_tag_i   (va_tag),
		.valid_i      (tc_vld_q[tc_idx]),
		.hit_o        (tc_hit),
		.miss_o       ()
	);
	tag_match #(
		.TAG_W        (`MC_TAG_W)
	) u_mc_match (
		.stored_tag_i (mc_old_tag),
		.addr_tag_i   (pa_tag),
		.valid_i      (mc_vld_q[mc_idx]),
		.hit_o        (mc_hit),
		.miss_o       ()
	);
	// longword half of a line: lower address sits in the upper bits (big-endian)
	wire        half_lo = va_q[`HALF_BIT];
	wire        walk_lo = mem_addr_q[`HALF_BIT];
	wire [31:0] walk_ent = walk_lo ? mem_rdata_i[31:0] : mem_rdata_i[63:32];

	// ************************************************************
	// byte merge of a longword write into a line
	// ************************************************************
	function [`LINE_W-1:0] merge_line;
		input [`LINE_W-1:0] line;
		input [3:0]         be;
		input [31:0]        wd;
		input               lo;
		reg   [31:0]        old;
		integer             i;
		begin
			old = lo ? line[31:0] : line[63:32];
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					old[i*8 +: 8] = wd[i*8 +: 8];
				end
			end
			merge_line = lo ? {line[63:32], old} : {old, line[31:0]};
		end
	endfunction

	wire [`LINE_W-1:0] hit_merged = merge_line(mc_line, be_q, wd_q, half_lo);
	wire [`LINE_W-1:0] dma_merged = merge_line(mem_rdata_i, be_q, wd_q, half_lo);

	// ************************************************************
	// array write strobes
	// ************************************************************
	wire tc_fill  = (state_q == S_PG_RD) && mem_ack_i && !dma_q;
	wire mc_fill  = (state_q == S_FILL) && mem_ack_i && !dma_q; // R05
	wire mc_write = (state_q == S_CACHE) && mc_hit && we_q;

	// ************************************************************
	// arrays without reset: data, tags and tables
	// ************************************************************
	always @(posedge clk_i) begin
		if (tbl_we_i && !tbl_map_i) begin
			grp_tab[tbl_idx_i[3:0]] <= tbl_data_i[`PPTR_W-1:0]; // R09
		end
		if (tbl_we_i && tbl_map_i) begin
			map_tab[tbl_idx_i] <= tbl_data_i; // R11
		end
		if (tc_fill) begin
			tc_ptr[tc_idx]  <= walk_ent[`PTE_PTR_LSB +: `PPTR_W]; // R14
			tc_perm[tc_idx] <= walk_ent[`PTE_PRM_LSB +: `PERM_W];
			tc_tag[tc_idx]  <= va_tag;
		end
		if (mc_fill) begin
			mc_data[mc_idx] <= mem_rdata_i; // R04
			mc_tag[mc_idx]  <= pa_tag;
		end else if (mc_write) begin
			mc_data[mc_idx] <= hit_merged;
		end
	end

	// ************************************************************
	// valid and dirty bits
	// ************************************************************
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tc_vld_q   <= {`TC_N{1'b0}}; // R17
			mc_vld_q   <= {`MC_N{1'b0}}; // R17
			mc_dirty_q <= {`MC_N{1'b0}};
		end else begin
			if (tc_fill) begin
				tc_vld_q[tc_idx] <= 1'b1;
			end
			if (mc_fill) begin
				mc_vld_q[mc_idx]   <= 1'b1;
				mc_dirty_q[mc_idx] <= 1'b0;
			end else if (mc_write) begin
				mc_dirty_q[mc_idx] <= 1'b1; // R06
			end
		end
	end

	// ************************************************************
	// request sequencer
	// ************************************************************
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q     <= S_IDLE;
			dma_q       <= 1'b0;
			we_q        <= 1'b0;
			va_q        <= {`VA_W{1'b0}};
			be_q        <= 4'h0;
			wd_q        <= 32'h0000_0000;
			ptr_q       <= {`PPTR_W{1'b0}};
			perm_q      <= {`PERM_W{1'b0}};
			done_q      <= 1'b0;
			rdata_q     <= 32'h0000_0000;
			tc_hit_q    <= 1'b0;
			mc_hit_q    <= 1'b0;
			mem_addr_q  <= {`PA_W{1'b0}};
			mem_wdata_q <= {`LINE_W{1'b0}};
		end else begin
			done_q <= 1'b0;
			case (state_q)
			S_IDLE: begin
				if (req_i) begin
					dma_q   <= req_dma_i;
					we_q    <= req_we_i;
					va_q    <= req_addr_i;
					be_q    <= req_be_i;
					wd_q    <= req_wdata_i;
					state_q <= S_XLATE;
				end
			end
			S_XLATE: begin
				// pointer source depends on who asks and on the cache
				if (dma_q) begin
					ptr_q     <= map_ent[`MAP_PTR_LSB +: `PPTR_W]; // R08
					perm_q    <= map_ent[`MAP_PRM_LSB +: `PERM_W];
					tc_hit_q  <= 1'b0;
					state_q   <= S_CACHE;
				end else if (tc_hit) begin
					ptr_q     <= tc_ptr[tc_idx]; // R08
					perm_q    <= tc_perm[tc_idx];
					tc_hit_q  <= 1'b1;
					state_q   <= S_CACHE;
				end else begin
					tc_hit_q   <= 1'b0;
					mem_addr_q <= {grp_tab[va_q[`GRP_MSB:`GRP_LSB]], va_q[`SEG_MSB:`SEG_LSB], 2'b00}; // R15
					state_q    <= S_SEG_RD;
				end
			end
			S_SEG_RD: begin
				if (mem_ack_i) begin
					mem_addr_q <= {walk_ent[`STE_PTR_LSB +: `STE_PTR_W], va_q[`PGI_MSB:`PGI_LSB], 2'b00};
					state_q    <= S_PG_RD;
				end
			end
			S_PG_RD: begin
				if (mem_ack_i) begin
					ptr_q   <= walk_ent[`PTE_PTR_LSB +: `PPTR_W]; // R08 R10
					perm_q  <= walk_ent[`PTE_PRM_LSB +: `PERM_W];
					state_q <= S_CACHE;
				end
			end
			S_CACHE: begin
				mc_hit_q <= mc_hit;
				if (mc_hit) begin
					rdata_q <= half_lo ? mc_line[31:0] : mc_line[63:32];
					done_q  <= 1'b1;
					state_q <= S_IDLE;
				end else if (dma_q) begin
					// no allocation for dma: go straight to memory
					mem_addr_q <= {pa[`PA_W-1:`MC_IDX_LSB], 3'b000}; // R05 R13
					state_q    <= S_DMA_RD;
				end else if (mc_vld_q[mc_idx] && mc_dirty_q[mc_idx]) begin
					mem_addr_q  <= {mc_old_tag, mc_idx, 3'b000}; // R16
					mem_wdata_q <= mc_line;
					state_q     <= S_WB;
				end else begin
					mem_addr_q <= {pa[`PA_W-1:`MC_IDX_LSB], 3'b000}; // R13
					state_q    <= S_FILL;
				end
			end
			S_WB: begin
				if (mem_ack_i) begin
					mem_addr_q <= {pa[`PA_W-1:`MC_IDX_LSB], 3'b000};
					state_q    <= S_FILL;
				end
			end
			S_FILL: begin
				// line now resident; the retry hits and does the read or write
				if (mem_ack_i) begin
					state_q <= S_CACHE;
				end
			end
			S_DMA_RD: begin
				if (mem_ack_i) begin
					rdata_q <= half_lo ? mem_rdata_i[31:0] : mem_rdata_i[63:32];
					if (we_q) begin
						mem_wdata_q <= dma_merged; // R13
						state_q     <= S_DMA_WR;
					end else begin
						done_q  <= 1'b1;
						state_q <= S_IDLE;
					end
				end
			end
			S_DMA_WR: begin
				if (mem_ack_i) begin
					done_q  <= 1'b1;
					state_q <= S_IDLE;
				end
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign busy_o      = (state_q != S_IDLE);
	assign done_o      = done_q;
	assign rdata_o     = rdata_q;
	assign paddr_o     = pa; // R07
	assign perm_o      = perm_q;
	assign tc_hit_o    = tc_hit_q;
	assign mc_hit_o    = mc_hit_q;
	assign mem_req_o   = (state_q == S_SEG_RD) || (state_q == S_PG_RD) || (state_q == S_WB) ||
	                     (state_q == S_FILL) || (state_q == S_DMA_RD) || (state_q == S_DMA_WR);
	assign mem_we_o    = (state_q == S_WB) || (state_q == S_DMA_WR);
	// walk entries are longwords, but the bus always moves the whole line
	assign mem_addr_o  = {mem_addr_q[`PA_W-1:3], 3'b000}; // R13
	assign mem_wdata_o = mem_wdata_q;

endmodule

// file: testbench/mem_model.sv
`timescale 1ns/1ps
`include "mmu_defs.vh"
// ************************************************************
// line memory behind the lookup block
// ************************************************************
module mem_model (
	input  wire               clk_i,
	input  wire               slow_i,
	input  wire               mem_req_i,
	input  wire               mem_we_i,
	input  wire [`PA_W-1:0]   mem_addr_i,
	input  wire [`LINE_W-1:0] mem_wdata_i,
	output reg                mem_ack_o,
	output reg  [`LINE_W-1:0] mem_rdata_o
);
	logic [`LINE_W-1:0] mem [logic [`PA_W-1:0]];
	logic [`PA_W:0]     log_q [$];
	logic [`LINE_W-1:0] wlog_q [$];
	int                 wait_q;
	initial begin
		mem_ack_o = 1'b0;
		mem_rdata_o = 64'h0000_0000_0000_0000;
		wait_q = 0;
	end
	// ack after one or four cycles; data toggles when not valid so stale reads show
	always @(posedge clk_i) begin
		mem_ack_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		if (mem_req_i && !mem_ack_o) begin
			if (wait_q < (slow_i ? 3 : 0)) begin
				wait_q <= wait_q + 1;
			end else begin
				wait_q <= 0;
				mem_ack_o <= 1'b1;
				log_q.push_back({mem_we_i, mem_addr_i});
				if (mem_we_i) begin
					mem[mem_addr_i] = mem_wdata_i;
					wlog_q.push_back(mem_wdata_i);
				end else begin
					mem_rdata_o <= mem.exists(mem_addr_i) ? mem[mem_addr_i] : {6'h00, mem_addr_i, 6'h00, mem_addr_i};
				end
			end
		end
	end
endmodule

// file: testbench/mmu_cache_lookup_assertions.sv
`timescale 1ns/1ps
`include "mmu_defs.vh"
// ************************************************************
// port checker for the lookup block
// ************************************************************
module mmu_cache_lookup_assertions (
	input wire logic            clk_i,
	input wire logic            reset_n_i,
	input wire logic            req_i,
	input wire logic            req_dma_i,
	input wire logic            req_we_i,
	input wire logic [`VA_W-1:0] req_addr_i,
	input wire logic            busy_o,
	input wire logic            done_o,
	input wire logic [`PA_W-1:0] paddr_o,
	input wire logic            tc_hit_o,
	input wire logic            mc_hit_o,
	input wire logic            mem_req_o,
	input wire logic            mem_we_o,
	input wire logic [`PA_W-1:0] mem_addr_o,
	input wire logic            mem_ack_i
);
	logic [`OFS_W-1:0] ofs_q;
	logic              dma_q;
	logic              we_q;
	logic              first_q;
	// remember the taken request; first_q marks the first one after reset
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ofs_q <= 12'h000;
			dma_q <= 1'b0;
			we_q <= 1'b0;
			first_q <= 1'b1;
		end else begin
			if (req_i && !busy_o) begin
				ofs_q <= req_addr_i[`OFS_W-1:0];
				dma_q <= req_dma_i;
				we_q <= req_we_i;
			end
			if (done_o) begin
				first_q <= 1'b0;
			end
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_cpu_rd;
		req_i && !busy_o && !req_dma_i && !req_we_i;
	endsequence
	sequence s_no_mem2;
		!mem_req_o [*2];
	endsequence
	property p_hit_latency;
		s_cpu_rd ##1 s_no_mem2 ##1 !mem_req_o |-> done_o && tc_hit_o && mc_hit_o;
	endproperty
	property p_miss_fetch;
		s_cpu_rd ##1 s_no_mem2 ##1 !done_o |-> mem_req_o;
	endproperty
	property p_first_miss;
		req_i && !busy_o && first_q |-> ##[1:4] mem_req_o;
	endproperty
	property p_line_align;
		mem_req_o |-> mem_addr_o[2:0] == 3'b000;
	endproperty
	property p_mem_hold;
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o);
	endproperty
	property p_ofs_pass;
		done_o |-> paddr_o[`OFS_W-1:0] == ofs_q;
	endproperty
	property p_dma_rd;
		mem_req_o && dma_q && !we_q |-> !mem_we_o;
	endproperty
	property p_dma_tc;
		done_o && dma_q |-> !tc_hit_o;
	endproperty
	a_hit_latency: assert property (p_hit_latency) else $error("hit not done in three cycles");
	a_miss_fetch: assert property (p_miss_fetch) else $error("miss without memory access");
	a_first_miss: assert property (p_first_miss) else $error("first access after reset hit");
	a_line_align: assert property (p_line_align) else $error("memory access not line aligned");
	a_mem_hold: assert property (p_mem_hold) else $error("memory request changed before ack");
	a_ofs_pass: assert property (p_ofs_pass) else $error("byte offset altered");
	a_dma_rd: assert property (p_dma_rd) else $error("dma read wrote memory");
	a_dma_tc: assert property (p_dma_tc) else $error("dma used translation cache");
endmodule
bind mmu_cache_lookup mmu_cache_lookup_assertions chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i),
	.req_dma_i(req_dma_i), .req_we_i(req_we_i), .req_addr_i(req_addr_i), .busy_o(busy_o), .done_o(done_o),
	.paddr_o(paddr_o), .tc_hit_o(tc_hit_o), .mc_hit_o(mc_hit_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
	.mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i));

// file: testbench/mmu_cache_lookup_bench.sv
`timescale 1ns/1ps
`include "mmu_defs.vh"
// ************************************************************
// self-checking bench for the lookup block
// ************************************************************
module mmu_cache_lookup_bench;
	localparam [29:0] VA1 = 30'h0402_3124;
	localparam [29:0] VA2 = 30'h0402_4124;
	localparam [29:0] VAD = 30'h0000_5124;
	logic clk_i = 1'b0, reset_n_i = 1'b0, slow_i = 1'b1;
	logic req_i = 1'b0, req_dma_i = 1'b0, req_we_i = 1'b0, tbl_we_i = 1'b0, tbl_map_i = 1'b0;
	logic [29:0] req_addr_i = 30'h0000_0000;
	logic [3:0] req_be_i = 4'h0;
	logic [31:0] req_wdata_i = 32'h0000_0000;
	logic [11:0] tbl_idx_i = 12'h000;
	logic [15:0] tbl_data_i = 16'h0000;
	logic busy_o, done_o, tc_hit_o, mc_hit_o, mem_req_o, mem_we_o, mem_ack_i;
	logic [31:0] rdata_o;
	logic [25:0] paddr_o, mem_addr_o;
	logic [1:0] perm_o;
	logic [63:0] mem_wdata_o, mem_rdata_i;
	int n_mismatch = 0, checked = 0, cyc = 0, n0;
	always #2 clk_i = ~clk_i;
	mmu_cache_lookup dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .req_dma_i(req_dma_i),
		.req_we_i(req_we_i), .req_addr_i(req_addr_i), .req_be_i(req_be_i), .req_wdata_i(req_wdata_i),
		.busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .paddr_o(paddr_o), .perm_o(perm_o),
		.tc_hit_o(tc_hit_o), .mc_hit_o(mc_hit_o), .tbl_we_i(tbl_we_i), .tbl_map_i(tbl_map_i),
		.tbl_idx_i(tbl_idx_i), .tbl_data_i(tbl_data_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
		.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
	mem_model mem_u (.clk_i(clk_i), .slow_i(slow_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o),
		.mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
	// hang guard: the ten accesses of the run fit well inside this
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize;
		if (n_mismatch == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t ns: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	// one request, held for the taking edge only, then wait for done
	task automatic access(input logic dma, input logic we, input logic [29:0] a, input logic [3:0] be,
		input logic [31:0] wd);
		int n;
		@(posedge clk_i);
		req_i <= 1'b1;
		req_dma_i <= dma;
		req_we_i <= we;
		req_addr_i <= a;
		req_be_i <= be;
		req_wdata_i <= wd;
		@(posedge clk_i);
		req_i <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (done_o !== 1'b1 && n < 300);
		check(n < 300, 1'b1);
	endtask
	task automatic load(input logic map, input logic [11:0] idx, input logic [15:0] d);
		@(posedge clk_i);
		tbl_we_i <= 1'b1;
		tbl_map_i <= map;
		tbl_idx_i <= idx;
		tbl_data_i <= d;
		@(posedge clk_i);
		tbl_we_i <= 1'b0;
	endtask
	// cold read: segment, page and line fetched in that order
	task automatic t_walk;
		n0 = mem_u.log_q.size();
		access(1'b0, 1'b0, VA1, 4'hf, 32'h0000_0000);
		check(rdata_o, 32'h3333_4444);
		check(paddr_o, {14'h0abc, 12'h124});
		check(perm_o, 2'b10);
		check({tc_hit_o, mc_hit_o}, 2'b01);
		check(mem_u.log_q[n0], 27'h001_0008);
		check(mem_u.log_q[n0+1], 27'h000_1008);
		check(mem_u.log_q[n0+2], 27'h0ab_c120);
	endtask
	task automatic t_hit;
		n0 = mem_u.log_q.size();
		access(1'b0, 1'b0, VA1, 4'hf, 32'h0000_0000);
		check(rdata_o, 32'h3333_4444);
		check({tc_hit_o, mc_hit_o}, 2'b11);
		check(mem_u.log_q.size(), n0);
	endtask
	// dirty line evicted by an alias, then refetched with merged bytes
	task automatic t_evict;
		slow_i <= 1'b0;
		access(1'b0, 1'b1, VA1, 4'b0011, 32'haaaa_bbbb);
		n0 = mem_u.log_q.size();
		access(1'b0, 1'b0, VA2, 4'hf, 32'h0000_0000);
		check(rdata_o, 32'h7777_8888);
		check(paddr_o, {14'h0a9c, 12'h124});
		check(mem_u.log_q[n0+2], 27'h4ab_c120);
		check(mem_u.wlog_q[$], 64'h1111_2222_3333_bbbb);
		access(1'b0, 1'b0, VA1, 4'hf, 32'h0000_0000);
		check(rdata_o, 32'h3333_bbbb);
		check(mem_u.log_q.size(), n0 + 5);
		check(mc_hit_o, 1'b1);
	endtask
	// dma read, write and read again through the mapper: no allocation in between
	task automatic t_dma;
		n0 = mem_u.log_q.size();
		access(1'b1, 1'b0, VAD, 4'hf, 32'h0000_0000);
		check(rdata_o, 32'h0002_3120);
		check(paddr_o, {14'h0023, 12'h124});
		check({perm_o, tc_hit_o}, 3'b010);
		access(1'b1, 1'b1, VAD, 4'b1100, 32'hcccc_dddd);
		check(mem_u.log_q[n0+2], 27'h402_3120);
		check(mem_u.wlog_q[$], 64'h0002_3120_cccc_3120);
		access(1'b1, 1'b0, VAD, 4'hf, 32'h0000_0000);
		check(rdata_o, 32'hcccc_3120);
		check(mc_hit_o, 1'b0);
		check(mem_u.log_q.size(), n0 + 4);
	endtask
	// reset in mid-run: caches forget, tables and memory stay; write miss, then dirty eviction
	task automatic t_reset;
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		n0 = mem_u.log_q.size();
		access(1'b0, 1'b1, VA1, 4'b1000, 32'h5500_0000);
		check({tc_hit_o, mc_hit_o}, 2'b01);
		check(mem_u.log_q.size(), n0 + 3);
		access(1'b0, 1'b0, VA2, 4'hf, 32'h0000_0000);
		check(mem_u.log_q[n0+5], 27'h4ab_c120);
		check(mem_u.wlog_q[$], 64'h1111_2222_5533_bbbb);
	endtask
	initial begin
		mem_u.mem[26'h001_0008] = 64'h0010_0040_0000_0000;
		mem_u.mem[26'h000_1008] = 64'h0000_0000_0000_8abc;
		mem_u.mem[26'h000_1010] = 64'h0000_8a9c_0000_0000;
		mem_u.mem[26'h0ab_c120] = 64'h1111_2222_3333_4444;
		mem_u.mem[26'h0a9_c120] = 64'h5555_6666_7777_8888;
		repeat (10) @(posedge clk_i);
		reset_n_i <= 1'b1;
		load(1'b0, 12'h001, 16'h0010);
		load(1'b1, 12'h005, 16'h4023);
		t_walk();
		t_hit();
		t_evict();
		t_dma();
		t_reset();
		summarize();
	end
endmodule
